// ===== design/pap_pkg.sv
// Purpose: Shared constants for the pulse accumulator and timer port block
// Assumes: Byte-wide register offsets, 16-bit register data path
// Notes: Control bits not given an address elsewhere sit at chosen offsets
`default_nettype none
package pap_pkg;
    // Register offsets
    localparam logic [7:0] PAP_OFS_TIMER_SYSTEM_CONTROL = 8'h86;
    localparam logic [7:0] PAP_OFS_TCNT = 8'h84;
    localparam logic [7:0] PAP_OFS_PACTL = 8'hA0;
    localparam logic [7:0] PAP_OFS_FLAGS = 8'hA1;
    localparam logic [7:0] PAP_OFS_COUNT = 8'hA2;
    localparam logic [7:0] PAP_OFS_TEST = 8'hAD;
    localparam logic [7:0] PAP_OFS_DATA = 8'hAE;
    localparam logic [7:0] PAP_OFS_DIR = 8'hAF;
    // Timer system control fields
    localparam int PAP_TSC_TIMER_ENABLE = 7;
    localparam int PAP_TSC_WAIT_STOP = 6;
    localparam int PAP_TSC_BACKGROUND_STOP = 5;
    localparam int PAP_TSC_FAST_CLEAR = 4;
    // Accumulator control fields
    localparam int PAP_CTL_SYSTEM_ENABLE = 6;
    localparam int PAP_CTL_MODE = 5;
    localparam int PAP_CTL_EDGE = 4;
    localparam int PAP_CTL_CLK_HI = 3;
    localparam int PAP_CTL_CLK_LO = 2;
    localparam int PAP_CTL_OVF_IE = 1;
    localparam int PAP_CTL_EDGE_IE = 0;
    // Flag and test fields
    localparam int PAP_FLG_OVERFLOW = 1;
    localparam int PAP_FLG_INPUT_EDGE = 0;
    localparam int PAP_TST_TIMER_BYP = 1;
    localparam int PAP_TST_ACCUM_BYP = 2;
    // Reset values
    localparam logic [7:0] PAP_RST_BYTE = 8'h00;
    localparam logic [15:0] PAP_RST_WORD = 16'h0000;
    // Timing counts: gate divide in module clocks, 256/65536 in accumulator clocks
    localparam int PAP_GATE_DIV = 64;
    localparam int PAP_ACC_DIV_MID = 256;
    localparam int PAP_ACC_DIV_HI = 65536;
    // Timer counter clock sources
    typedef enum logic [1:0] {
        PAP_CLK_PRESC = 2'b00,
        PAP_CLK_ACC = 2'b01,
        PAP_CLK_ACC256 = 2'b10,
        PAP_CLK_ACC64K = 2'b11
    } pap_clk_sel_t;
endpackage : pap_pkg
`default_nettype wire

// ===== design/pap_top.sv
// Contract
// - Event mode counts falling edges if edge select is 0, rising if 1.
// - Gated mode, edge select 0: high input gates divided clock; fall sets flag.
// - Gated mode, edge select 1: low input gates divided clock; rise sets flag.
// - With timer disabled no divide-by-64 clock reaches the accumulator.
// - Clock select picks prescaler, accumulator clock, or it divided by 256/65536.
// - Accumulator disabled means timer counter always uses prescaler clock.
// - Clock select change takes effect at once, no synchronisation wait.
// - Interrupt requested by overflow flag or input flag with its enable set.
// - Fast clear mode: any count register access clears both flags.
// - Overflow flag sets on 16-bit wrap; write bit 1 as one clears it.
// - Input flag sets on event or gate trailing edge; write bit 0 clears.
// - Test register always readable, writable only when special_mode_n is 0.
// - Timer bypass splits timer counter in two halves, skips prescaler.
// - Accumulator bypass splits pulse counter in two halves, skips divide-by-64 gate clock.
// - Port data read gives pin level for inputs, driver input for outputs.
// - Port data writes land in a latch; timer-owned pins stay unaffected.
// - Direction bit 0 input, 1 output; enabled compare forces output.
// - Disabled compare returns control to direction bit; capture never overrides.
// - Timer runs in background and wait unless the matching stop bit is 1.
// - Disabled timer or accumulator stops its operations; registers stay usable.
//
// Purpose: Pulse accumulator, timer counter clocking and timer port pins
// Assumes: Register port with one-cycle strobes, read data one cycle later
// Notes: Pin 7 is the accumulator input; compare channels are external
`default_nettype none
module pap_top
    import pap_pkg::*;
#(
    parameter int PRESC_DIV = 1
)
(
    // Clock, reset, enable
    input wire logic clk,
    input wire logic rst_n,
    input wire logic ce,
    // Register port
    input wire logic [7:0] addr,
    input wire logic [15:0] wr_data,
    input wire logic wr_stb,
    input wire logic rd_stb,
    output logic [15:0] rd_data,
    // Chip mode
    input wire logic special_mode_n,
    input wire logic background_mode,
    input wire logic wait_mode,
    // Output compare channels
    input wire logic [7:0] oc_enable,
    input wire logic [7:0] oc_level,
    // Timer port pins
    input wire logic [7:0] port_in,
    output logic [7:0] port_out,
    output logic [7:0] port_oe,
    // Interrupt request
    output logic irq
);
    logic rst_meta_ff;
    logic rst_sync_n_ff;
    logic [7:0] tsc_ff;
    logic [7:0] pactl_ff;
    logic [7:0] test_ff;
    logic [7:0] dir_ff;
    logic [7:0] data_ff;
    logic ovf_flag_ff;
    logic edge_flag_ff;
    logic [15:0] count_ff;
    logic [15:0] tcnt_ff;
    logic [7:0] presc_ff;
    logic [5:0] div64_ff;
    logic [15:0] acc_div_ff;
    logic pin_meta_ff;
    logic pin_sync_ff;
    logic pin_prev_ff;
    logic [15:0] rd_data_ff;
    logic irq_ff;
    logic [7:0] port_out_ff;
    logic [7:0] port_oe_ff;

    // Reset release through two flops
    always_ff @(posedge clk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            rst_meta_ff <= 1'b0;
            rst_sync_n_ff <= 1'b0;
        end
        else
        begin
            rst_meta_ff <= 1'b1;
            rst_sync_n_ff <= rst_meta_ff;
        end
    end

    // Address decode
    wire sel_tsc = (addr == PAP_OFS_TIMER_SYSTEM_CONTROL);
    wire sel_tcnt = (addr == PAP_OFS_TCNT);
    wire sel_pactl = (addr == PAP_OFS_PACTL);
    wire sel_flags = (addr == PAP_OFS_FLAGS);
    wire sel_count = (addr == PAP_OFS_COUNT);
    wire sel_test = (addr == PAP_OFS_TEST);
    wire sel_data = (addr == PAP_OFS_DATA);
    wire sel_dir = (addr == PAP_OFS_DIR);
    wire wr_tsc = wr_stb && sel_tsc;
    wire wr_tcnt = wr_stb && sel_tcnt;
    wire wr_pactl = wr_stb && sel_pactl;
    wire wr_flags = wr_stb && sel_flags;
    wire wr_count = wr_stb && sel_count;
    wire wr_test = wr_stb && sel_test && !special_mode_n;
    wire wr_data_reg = wr_stb && sel_data;
    wire wr_dir = wr_stb && sel_dir;

    // Control fields
    wire fast_clear = tsc_ff[PAP_TSC_FAST_CLEAR];
    wire timer_active = tsc_ff[PAP_TSC_TIMER_ENABLE]
        && !(background_mode && tsc_ff[PAP_TSC_BACKGROUND_STOP])
        && !(wait_mode && tsc_ff[PAP_TSC_WAIT_STOP]);
    wire accum_system_enable = pactl_ff[PAP_CTL_SYSTEM_ENABLE];
    wire accum_mode_select = pactl_ff[PAP_CTL_MODE];
    wire edge_select = pactl_ff[PAP_CTL_EDGE];
    wire timer_chain_bypass = test_ff[PAP_TST_TIMER_BYP];
    wire accum_chain_bypass = test_ff[PAP_TST_ACCUM_BYP];
    pap_clk_sel_t clock_select;
    assign clock_select = pap_clk_sel_t'({pactl_ff[PAP_CTL_CLK_HI],
        pactl_ff[PAP_CTL_CLK_LO]});

    // Timer prescaler and the divide-by-64 gate clock
    localparam logic [7:0] PRESC_LAST = 8'(PRESC_DIV - 1);
    localparam logic [5:0] DIV64_LAST = 6'(PAP_GATE_DIV - 1);
    wire presc_wrap = (presc_ff == PRESC_LAST);
    wire presc_tick = timer_active && (timer_chain_bypass || presc_wrap);
    wire div64_tick = timer_active && (div64_ff == DIV64_LAST);

    // Accumulator input edges after the synchroniser
    wire pin_rise = pin_sync_ff && !pin_prev_ff;
    wire pin_fall = !pin_sync_ff && pin_prev_ff;
    wire sel_edge = edge_select ? pin_rise : pin_fall;
    wire gate_open = edge_select ? !pin_sync_ff : pin_sync_ff;
    // Bypass lets the gate pass module clocks directly, skipping the divider
    wire gate_clk = accum_chain_bypass ? timer_active : div64_tick;
    wire accum_clock = accum_system_enable && (accum_mode_select ?
        (gate_open && gate_clk) : sel_edge);
    wire edge_event = accum_system_enable && sel_edge;

    // Pulse counter, whole or as two independent halves
    wire [7:0] cnt_lo_inc = count_ff[7:0] + 8'h01;
    wire [7:0] cnt_hi_split = count_ff[15:8] + 8'h01;
    wire [15:0] cnt_whole = count_ff + 16'h0001;
    wire [15:0] cnt_next_inc = accum_chain_bypass ?
        {cnt_hi_split, cnt_lo_inc} : cnt_whole;
    wire cnt_wrap = accum_chain_bypass ? (count_ff[15:8] == 8'hFF)
        : (count_ff == 16'hFFFF);
    wire ovf_event = accum_clock && cnt_wrap && !wr_count;
    wire count_access = (wr_stb || rd_stb) && sel_count;
    wire fast_hit = fast_clear && count_access;

    // Accumulator clock dividers for the timer counter
    localparam logic [15:0] ACC_MID_MASK = 16'(PAP_ACC_DIV_MID - 1);
    localparam logic [15:0] ACC_HI_MASK = 16'(PAP_ACC_DIV_HI - 1);
    wire acc_div256 = accum_clock
        && ((acc_div_ff & ACC_MID_MASK) == ACC_MID_MASK);
    wire acc_div64k = accum_clock
        && ((acc_div_ff & ACC_HI_MASK) == ACC_HI_MASK);
    logic tcnt_src;
    always_comb
    begin
        tcnt_src = presc_tick;
        if (accum_system_enable)
        begin
            unique case (clock_select)
                PAP_CLK_PRESC: tcnt_src = presc_tick;
                PAP_CLK_ACC: tcnt_src = accum_clock;
                PAP_CLK_ACC256: tcnt_src = acc_div256;
                PAP_CLK_ACC64K: tcnt_src = acc_div64k;
            endcase
        end
    end
    wire tcnt_tick = tcnt_src && timer_active;
    wire [15:0] tcnt_next_inc = timer_chain_bypass ?
        {8'(tcnt_ff[15:8] + 8'h01), 8'(tcnt_ff[7:0] + 8'h01)}
        : 16'(tcnt_ff + 16'h0001);

    // Flags: hardware set wins over any clear in the same cycle
    wire nxt_ovf_flag = ovf_event || (ovf_flag_ff
        && !(wr_flags && wr_data[PAP_FLG_OVERFLOW]) && !fast_hit);
    wire nxt_edge_flag = edge_event || (edge_flag_ff
        && !(wr_flags && wr_data[PAP_FLG_INPUT_EDGE]) && !fast_hit);
    wire nxt_irq = (nxt_ovf_flag && pactl_ff[PAP_CTL_OVF_IE])
        || (nxt_edge_flag && pactl_ff[PAP_CTL_EDGE_IE]);

    // Pins: compare overrides direction and data, capture does not
    logic [7:0] nxt_port_oe;
    logic [7:0] nxt_port_out;
    logic [7:0] pin_view;
    genvar gi;
    generate
        for (gi = 0; gi < 8; gi++)
        begin : g_pin
            assign nxt_port_oe[gi] = dir_ff[gi] || oc_enable[gi];
            assign nxt_port_out[gi] = oc_enable[gi] ? oc_level[gi]
                : (wr_data_reg ? wr_data[gi] : data_ff[gi]);
            if (gi == 7)
            begin : g_acc
                assign pin_view[gi] = port_oe_ff[gi] ? port_out_ff[gi]
                    : pin_sync_ff;
            end
            else
            begin : g_gpio
                assign pin_view[gi] = port_oe_ff[gi] ? port_out_ff[gi]
                    : port_in[gi];
            end
        end
    endgenerate

    // Read mux; unmapped offsets return zero
    logic [15:0] rd_mux;
    always_comb
    begin
        rd_mux = PAP_RST_WORD;
        if (sel_tsc)
            rd_mux = {8'h00, tsc_ff};
        else if (sel_tcnt)
            rd_mux = tcnt_ff;
        else if (sel_pactl)
            rd_mux = {8'h00, pactl_ff};
        else if (sel_flags)
            rd_mux = {14'h0000, ovf_flag_ff, edge_flag_ff};
        else if (sel_count)
            rd_mux = count_ff;
        else if (sel_test)
            rd_mux = {8'h00, test_ff};
        else if (sel_data)
            rd_mux = {8'h00, pin_view};
        else if (sel_dir)
            rd_mux = {8'h00, dir_ff};
    end

    // Control registers
    always_ff @(posedge clk or negedge rst_sync_n_ff)
    begin
        if (!rst_sync_n_ff)
        begin
            tsc_ff <= PAP_RST_BYTE;
            pactl_ff <= PAP_RST_BYTE;
            test_ff <= PAP_RST_BYTE;
            dir_ff <= PAP_RST_BYTE;
            data_ff <= PAP_RST_BYTE;
        end
        else if (ce)
        begin
            if (wr_tsc)
                tsc_ff <= wr_data[7:0];
            if (wr_pactl)
                pactl_ff <= wr_data[7:0];
            if (wr_test)
                test_ff <= wr_data[7:0];
            if (wr_dir)
                dir_ff <= wr_data[7:0];
            if (wr_data_reg)
                data_ff <= wr_data[7:0];
        end
    end

    // Input synchroniser and edge history
    always_ff @(posedge clk or negedge rst_sync_n_ff)
    begin
        if (!rst_sync_n_ff)
        begin
            pin_meta_ff <= 1'b0;
            pin_sync_ff <= 1'b0;
            pin_prev_ff <= 1'b0;
        end
        else if (ce)
        begin
            pin_meta_ff <= port_in[7];
            pin_sync_ff <= pin_meta_ff;
            pin_prev_ff <= pin_sync_ff;
        end
    end

    // Dividers; the gate divider only runs with the timer active
    always_ff @(posedge clk or negedge rst_sync_n_ff)
    begin
        if (!rst_sync_n_ff)
        begin
            presc_ff <= PAP_RST_BYTE;
            div64_ff <= 6'h00;
            acc_div_ff <= PAP_RST_WORD;
        end
        else if (ce)
        begin
            if (timer_active)
            begin
                presc_ff <= presc_wrap ? PAP_RST_BYTE : 8'(presc_ff + 8'h01);
                div64_ff <= 6'(div64_ff + 6'h01);
            end
            if (accum_clock)
                acc_div_ff <= 16'(acc_div_ff + 16'h0001);
        end
    end

    // Counters; a software write wins over a count in the same cycle
    always_ff @(posedge clk or negedge rst_sync_n_ff)
    begin
        if (!rst_sync_n_ff)
        begin
            count_ff <= PAP_RST_WORD;
            tcnt_ff <= PAP_RST_WORD;
        end
        else if (ce)
        begin
            if (wr_count)
                count_ff <= wr_data;
            else if (accum_clock)
                count_ff <= cnt_next_inc;
            if (wr_tcnt)
                tcnt_ff <= wr_data;
            else if (tcnt_tick)
                tcnt_ff <= tcnt_next_inc;
        end
    end

    // Flags, interrupt, pins and read data
    always_ff @(posedge clk or negedge rst_sync_n_ff)
    begin
        if (!rst_sync_n_ff)
        begin
            ovf_flag_ff <= 1'b0;
            edge_flag_ff <= 1'b0;
            irq_ff <= 1'b0;
            port_out_ff <= PAP_RST_BYTE;
            port_oe_ff <= PAP_RST_BYTE;
            rd_data_ff <= PAP_RST_WORD;
        end
        else if (ce)
        begin
            ovf_flag_ff <= nxt_ovf_flag;
            edge_flag_ff <= nxt_edge_flag;
            irq_ff <= nxt_irq;
            port_out_ff <= nxt_port_out;
            port_oe_ff <= nxt_port_oe;
            rd_data_ff <= rd_stb ? rd_mux : PAP_RST_WORD;
        end
    end

    assign rd_data = rd_data_ff;
    assign irq = irq_ff;
    assign port_out = port_out_ff;
    assign port_oe = port_oe_ff;
endmodule : pap_top
`default_nettype wire

// ===== verification/pap_properties.sv
// Purpose: Port properties of the pulse accumulator block
// Assumes: ce held high; register values mirrored from bus writes
// Notes: Checks wait until the internal reset has surely ended
`default_nettype none
module pap_props
    import pap_pkg::*;
(
    // Clock, reset and register port
    input wire logic clk,
    input wire logic rst_n,
    input wire logic [7:0] addr,
    input wire logic [15:0] wr_data,
    input wire logic wr_stb,
    input wire logic rd_stb,
    input wire logic [15:0] rd_data,
    // Mode, compare channels and pins
    input wire logic special_mode_n,
    input wire logic [7:0] oc_enable,
    input wire logic [7:0] oc_level,
    input wire logic [7:0] port_out,
    input wire logic [7:0] port_oe,
    input wire logic irq
);
    logic [2:0] live_ff;
    logic [7:0] dir_ff;
    logic [1:0] ie_ff;
    logic [1:0] tst_ff;
    wire logic wr_dir = wr_stb && addr == PAP_OFS_DIR;
    wire logic wr_ctl = wr_stb && addr == PAP_OFS_PACTL;
    wire logic wr_tst = wr_stb && addr == PAP_OFS_TEST && !special_mode_n;
    // Internal reset lasts two edges past rst_n, so wait for three
    always_ff @(posedge clk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            live_ff <= 3'h0;
            dir_ff <= 8'h00;
            ie_ff <= 2'h0;
            tst_ff <= 2'h0;
        end
        else
        begin
            live_ff <= {live_ff[1:0], 1'b1};
            if (wr_dir)
                dir_ff <= wr_data[7:0];
            if (wr_ctl)
                ie_ff <= wr_data[1:0];
            if (wr_tst)
                tst_ff <= wr_data[2:1];
        end
    end
    default clocking cb @(posedge clk);
    endclocking
    default disable iff (!rst_n || !live_ff[2]);
    AST_RD_QUIET: assert property (!$past(rd_stb) |-> rd_data == 16'h0000)
        else $error("read data outside its slot");
    AST_DIR_OE: assert property (port_oe == ($past(dir_ff) | $past(oc_enable)))
        else $error("pin enable differs from direction or compare");
    AST_OC_LEVEL: assert property
        (((port_out ^ $past(oc_level)) & $past(oc_enable)) == 8'h00)
        else $error("compare pin not at compare level");
    AST_DIR_READ: assert property
        ($past(rd_stb) && $past(addr) == PAP_OFS_DIR |-> rd_data[7:0] == $past(dir_ff))
        else $error("direction read back wrong");
    AST_TEST_GUARD: assert property
        ($past(rd_stb) && $past(addr) == PAP_OFS_TEST |-> rd_data[2:1] == $past(tst_ff))
        else $error("test register took a write outside special mode");
    AST_OUT_READ: assert property ($past(rd_stb) && $past(addr) == PAP_OFS_DATA
        |-> ((rd_data[7:0] ^ $past(port_out)) & $past(port_oe)) == 8'h00)
        else $error("output pin read is not the driver level");
    AST_IRQ_MASK: assert property ($past(ie_ff) == 2'b00 |-> !irq)
        else $error("interrupt with both enables off");
    AST_OE_STEADY: assert property
        ((oc_enable == 8'h00 && $stable(dir_ff)) [*2] |=> port_oe == $past(dir_ff))
        else $error("direction not back in control");
endmodule : pap_props
bind pap_top pap_props u_props (
    .clk(clk), .rst_n(rst_n), .addr(addr), .wr_data(wr_data),
    .wr_stb(wr_stb), .rd_stb(rd_stb), .rd_data(rd_data),
    .special_mode_n(special_mode_n), .oc_enable(oc_enable),
    .oc_level(oc_level), .port_out(port_out), .port_oe(port_oe), .irq(irq)
);
`default_nettype wire

// ===== verification/pap_pulse_src.sv
// Purpose: External pulse source on the accumulator input pin
// Assumes: Started by a one-cycle request, pin always driven
// Notes: Each level lasts at least three clocks for the synchroniser
`default_nettype none
module pap_pulse_src (
    // Bench control
    input wire logic clk,
    input wire logic start,
    input wire logic [7:0] n_pulses,
    input wire logic [7:0] width,
    input wire logic idle_lvl,
    // Pin side
    output logic pin,
    output logic busy
);
    timeunit 1ns;
    timeprecision 100ps;
    logic flip = 1'b0;
    assign pin = idle_lvl ^ flip;
    initial busy = 1'b0;
    always @(posedge clk)
    begin
        if (start && !busy)
        begin
            busy <= 1'b1;
            for (int i = 0; i < 2 * n_pulses; i++)
            begin
                repeat (width < 8'h03 ? 8'h03 : width) @(posedge clk);
                flip <= ~flip;
            end
            busy <= 1'b0;
        end
    end
endmodule : pap_pulse_src
`default_nettype wire

// ===== verification/test_pulse_accumulator_port.sv
// Purpose: Self-checking bench for the pulse accumulator block
// Assumes: ce tied high; prescaler divide set to 2
// Notes: Gated counts are judged in a window, sync delay blurs edges
`default_nettype none
module test_pulse_accumulator_port
    import pap_pkg::*;
;
    timeunit 1ns;
    timeprecision 100ps;
    localparam logic [7:0] OFS_SYS = 8'h86;
    logic clk = 1'b0;
    logic rst_n = 1'b0;
    logic [7:0] addr = 8'h00;
    logic [15:0] wr_data = 16'h0000;
    logic wr_stb = 1'b0;
    logic rd_stb = 1'b0;
    logic special_mode_n = 1'b1;
    logic bkg = 1'b0;
    logic wt = 1'b0;
    logic [7:0] oc_en = 8'h00;
    logic [7:0] oc_lv = 8'h00;
    logic [6:0] pin_lo = 7'h00;
    logic go = 1'b0;
    logic idle = 1'b1;
    logic [7:0] npul = 8'h01;
    logic [7:0] width = 8'h04;
    logic [15:0] rd_data, v;
    logic [7:0] port_out, port_oe, oe, po, d8;
    logic irq, busy, pin, ok;
    logic [31:0] seed = 32'h0000_6cd3;
    logic [7:0] offs [7] = '{OFS_SYS, PAP_OFS_TCNT, PAP_OFS_PACTL,
        PAP_OFS_FLAGS, PAP_OFS_COUNT, PAP_OFS_DIR, 8'h50};
    int n_errors = 0;
    int check_count = 0;
    int lo, hi;
    pap_top #(.PRESC_DIV(2)) u_dut (.clk(clk), .rst_n(rst_n), .ce(1'b1),
        .addr(addr), .wr_data(wr_data), .wr_stb(wr_stb), .rd_stb(rd_stb),
        .rd_data(rd_data), .special_mode_n(special_mode_n),
        .background_mode(bkg), .wait_mode(wt), .oc_enable(oc_en),
        .oc_level(oc_lv), .port_in({pin, pin_lo}), .port_out(port_out),
        .port_oe(port_oe), .irq(irq));
    pap_pulse_src u_src (.clk(clk), .start(go), .n_pulses(npul),
        .width(width), .idle_lvl(idle), .pin(pin), .busy(busy));
    initial
    begin
        forever #50 clk = ~clk;
    end
    function automatic logic [31:0] lfsr(input logic [31:0] s);
        return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
    endfunction : lfsr
    task automatic end_sim;
        if (n_errors == 0 && check_count > 0)
            $display("== PASSED ==");
        else
            $display("== FAILED ==");
        $finish;
    endtask : end_sim
    task automatic check(input logic [15:0] seen, input logic [15:0] exp);
        check_count++;
        if (seen !== exp)
        begin
            n_errors++;
            $display("[FAIL] %0t: got %h expected %h", $time, seen, exp);
        end
    endtask : check
    task automatic cyc(input int n);
        repeat (n) @(posedge clk);
    endtask : cyc
    // Every task starts just after an edge and returns just after one
    task automatic wr(input logic [7:0] a, input logic [15:0] d);
        addr <= a;
        wr_data <= d;
        wr_stb <= 1'b1;
        @(posedge clk);
        wr_stb <= 1'b0;
        @(posedge clk);
    endtask : wr
    task automatic rd(input logic [7:0] a, output logic [15:0] d);
        addr <= a;
        rd_stb <= 1'b1;
        @(posedge clk);
        rd_stb <= 1'b0;
        #1;
        d = rd_data;
        @(posedge clk);
    endtask : rd
    task automatic rc(input logic [7:0] a, input logic [15:0] exp);
        logic [15:0] d;
        rd(a, d);
        check(d, exp);
    endtask : rc
    task automatic pulse(input logic [7:0] n, input logic [7:0] w);
        npul <= n;
        width <= w;
        go <= 1'b1;
        @(posedge clk);
        go <= 1'b0;
        @(posedge clk);
    endtask : pulse
    task automatic wait_idle;
        for (int i = 0; i < 4000 && busy; i++)
            @(posedge clk);
        cyc(4);
    endtask : wait_idle
    initial
    begin
        repeat (20000) @(posedge clk);
        n_errors++;
        end_sim;
    end
    initial
    begin
        cyc(2);
        rst_n <= 1'b1;
        cyc(3);
        wr(8'h50, 16'hffff);
        foreach (offs[i])
            rc(offs[i], 16'h0000);
        seed = lfsr(seed);
        wr(PAP_OFS_COUNT, seed[15:0]);
        pulse(8'h03, 8'h04);
        wait_idle;
        rc(PAP_OFS_COUNT, seed[15:0]);
        for (int es = 0; es < 2; es++)
        begin
            wr(PAP_OFS_PACTL, 16'h0043 | (16'(es) << PAP_CTL_EDGE));
            wr(PAP_OFS_COUNT, 16'hffff);
            wr(PAP_OFS_FLAGS, 16'h0003);
            pulse(8'h01, 8'h10);
            cyc(22);
            rc(PAP_OFS_COUNT, es == 0 ? 16'h0000 : 16'hffff);
            wait_idle;
            rc(PAP_OFS_FLAGS, 16'h0003);
            check(16'(irq), 16'h0001);
            wr(PAP_OFS_FLAGS, 16'h0001);
            rc(PAP_OFS_FLAGS, 16'h0002);
            wr(PAP_OFS_FLAGS, 16'h0002);
            rc(PAP_OFS_FLAGS, 16'h0000);
            check(16'(irq), 16'h0000);
        end
        wr(OFS_SYS, 16'h0090);
        pulse(8'h01, 8'h04);
        wait_idle;
        rc(PAP_OFS_FLAGS, 16'h0001);
        rd(PAP_OFS_COUNT, v);
        rc(PAP_OFS_FLAGS, 16'h0000);
        // Gate level follows edge select; k of 2 and 3 run with the timer off
        for (int k = 0; k < 4; k++)
        begin
            wr(OFS_SYS, k[1] ? 16'h0000 : 16'h0080);
            idle <= k[0];
            wr(PAP_OFS_PACTL, 16'h0060 | (16'(k[0]) << PAP_CTL_EDGE));
            wr(PAP_OFS_COUNT, 16'h0000);
            wr(PAP_OFS_FLAGS, 16'h0003);
            pulse(8'h01, 8'hfa);
            wait_idle;
            hi = k[1] ? 0 : 250 / PAP_GATE_DIV + 1;
            lo = k[1] ? 0 : hi - 2;
            rd(PAP_OFS_COUNT, v);
            check(16'(v >= 16'(lo) && v <= 16'(hi)), 16'h0001);
            if (!k[1])
                rc(PAP_OFS_FLAGS, 16'h0001);
        end
        wr(OFS_SYS, 16'h0080);
        for (int s = 0; s < 5; s++)
        begin
            wr(PAP_OFS_PACTL, s < 4 ? 16'h0040 | 16'(s << 2) : 16'h0004);
            wr(PAP_OFS_TCNT, 16'h0000);
            pulse(8'h03, 8'h04);
            wait_idle;
            rd(PAP_OFS_TCNT, v);
            ok = s == 1 ? v === 16'h0003 : (s == 2 || s == 3) ?
                v === 16'h0000 : v >= 16'h0008;
            check(16'(ok), 16'h0001);
        end
        wr(OFS_SYS, 16'h00c0);
        wt <= 1'b1;
        bkg <= 1'b1;
        wr(PAP_OFS_TCNT, 16'h0000);
        cyc(20);
        rc(PAP_OFS_TCNT, 16'h0000);
        wt <= 1'b0;
        cyc(20);
        rd(PAP_OFS_TCNT, v);
        check(16'(v >= 16'h0008), 16'h0001);
        wr(PAP_OFS_TEST, 16'h0006);
        rc(PAP_OFS_TEST, 16'h0000);
        special_mode_n <= 1'b0;
        wr(PAP_OFS_TEST, 16'h0002);
        rc(PAP_OFS_TEST, 16'h0002);
        wr(PAP_OFS_TCNT, 16'h00fe);
        cyc(6);
        rd(PAP_OFS_TCNT, v);
        d8 = v[7:0] - v[15:8];
        check({8'h00, d8}, 16'h00fe);
        wr(PAP_OFS_TEST, 16'h0000);
        for (int i = 0; i < 6; i++)
        begin
            seed = lfsr(seed);
            oc_en <= seed[7:0];
            oc_lv <= seed[15:8];
            pin_lo <= seed[22:16];
            wr(PAP_OFS_DIR, {8'h00, seed[31:24]});
            wr(PAP_OFS_DATA, {8'h00, seed[23:16]});
            oe = seed[31:24] | seed[7:0];
            po = (seed[7:0] & seed[15:8]) | (~seed[7:0] & seed[23:16]);
            cyc(2);
            #1;
            check({8'h00, port_oe}, {8'h00, oe});
            check({8'h00, port_out}, {8'h00, po});
            rc(PAP_OFS_DATA, {8'h00, (oe & po) | (~oe & {pin, pin_lo})});
            oc_en <= 8'h00;
            cyc(2);
            #1;
            check({8'h00, port_oe}, {8'h00, seed[31:24]});
            check({8'h00, port_out}, {8'h00, seed[23:16]});
            @(posedge clk);
        end
        end_sim;
    end
endmodule : test_pulse_accumulator_port
`default_nettype wire
